// ### inc/adc_port_defs.svh
// Purpose: constants of the serial host port
// Assumes: mclk at 25 MHz
// Notes: word lengths in bits
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH
`define WLEN_RESET 2'h1
`define WLEN_16 2'h0
`define WLEN_24 2'h1
`define WLEN_32Z 2'h2
`define WLEN_32S 2'h3
`define CMD_WREG 3'h3
`define REG_MODE 6'h02
`define REG_CLOCK 6'h03
`define REG_DCBLK 6'h0f
`define REG_RSVD 6'h3f
`define MODE_RESET 16'h0510
`define CLOCK_RESET 16'h0f0e
`define DCBLK_RESET 16'h0000
`define RSVD_RESET 16'h0000
`define MODE_WLEN_LSB 8
`define MODE_DATA_READY_N_PULSE_BIT 0
`define CLOCK_CH_LSB 8
`define DCBLK_LSB 0
`define DATA_READY_N_PULSE_CYCLES 4'h2
`endif

// ### inc/adc_port_pkg.sv
// Purpose: types of the serial host port
// Assumes: nothing
// Notes: none
package adc_port_pkg;
  typedef logic [1:0] wlen_t;
  typedef logic [23:0] sample_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } frame_e;
endpackage : adc_port_pkg

// ### rtl/sample_queue.sv
// Purpose: two-deep queue of conversion results
// Assumes: one push per data period at most
// Notes: when full a push drops the oldest entry
`timescale 1ns/10ps
`default_nettype none
module sample_queue #(
  parameter int WIDTH = 72
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head_r,
  output logic [1:0] count_r
);
  logic [WIDTH-1:0] slot_r;
  logic [WIDTH-1:0] slot_nxt;
  logic [WIDTH-1:0] head_nxt;
  logic [1:0] count_nxt;
  initial begin
    if (WIDTH < 1) $error("sample_queue: width too small");
  end
  always_comb begin
    head_nxt = head_r;
    slot_nxt = slot_r;
    count_nxt = count_r;
    if (pop && count_r != 2'h0) begin
      head_nxt = slot_r;
      count_nxt = count_r - 2'h1;
    end
    if (push) begin
      if (count_nxt == 2'h0) begin
        head_nxt = push_data;
        count_nxt = 2'h1;
      end else if (count_nxt == 2'h1) begin
        slot_nxt = push_data;
        count_nxt = 2'h2;
      end else begin
        head_nxt = slot_r;
        slot_nxt = push_data;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      head_r <= '0;
      slot_r <= '0;
      count_r <= 2'h0;
    end else begin
      head_r <= head_nxt;
      slot_r <= slot_nxt;
      count_r <= count_nxt;
    end
  end
endmodule : sample_queue
`default_nettype wire

// ### rtl/adc_frame_serial_host_port.sv
// Purpose: serial target port framing conversion data
// Assumes: sclk/cs_n/sdi/sync_reset_n asynchronous, sampled by mclk
// Notes: mode 1 (shift out on rising, sample on falling sclk)
// Functional notes
// - dout released while select high
// - word length 24 bits after reset
// - 32-bit words sign-extend the result in WLEN_32S, zero-pad it in WLEN_32Z
// - frame: status, channel words, optional crc slot sent as zeros
// - short frames accepted (end in ST_DONE) only with channels disabled, otherwise abandoned to idle
// - data ready timing common across devices
// - dc-blocking filter setting held in a register (dcblk_cfg_r)
// - two-deep queue, overflow raises no data-ready pulse
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defs.svh"
module adc_frame_serial_host_port #(
  parameter int CHANNELS = 3,
  parameter bit CRC_EN = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  output logic data_ready_n,
  input wire logic sync_reset_n,
  input wire logic conv_valid,
  input wire adc_port_pkg::sample_t conv_ch0,
  input wire adc_port_pkg::sample_t conv_ch1,
  input wire adc_port_pkg::sample_t conv_ch2,
  output logic [15:0] dcblk_cfg_r,
  output logic sync_seen_r
);
  import adc_port_pkg::*;
  localparam int NW = CHANNELS + 2;
  initial begin
    if (CHANNELS != 3) $error("adc port: three channels only");
  end
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic sclk_d_r;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      // idle pin levels: sync high, sdi low, select high, sclk low
      s1_r <= 4'ha;
      s2_r <= 4'ha;
      sclk_d_r <= 1'b0;
    end else begin
      s1_r <= {sync_reset_n, sdi, cs_n, sclk};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[0];
    end
  end
  wire sclk_s = s2_r[0];
  wire cs_s = s2_r[1];
  wire sdi_s = s2_r[2];
  wire sync_s = s2_r[3];
  wire sclk_rise = sclk_s && !sclk_d_r;
  wire sclk_fall = !sclk_s && sclk_d_r;
  // ----------------------------------------
  // queue of results
  // ----------------------------------------
  logic [71:0] head;
  logic [1:0] qcount;
  logic pop;
  sample_queue #(.WIDTH(72)) u_queue (
    .mclk(mclk),
    .rst_b(rst_b),
    .push(conv_valid),
    .push_data({conv_ch2, conv_ch1, conv_ch0}),
    .pop(pop),
    .head_r(head),
    .count_r(qcount)
  );
  // ----------------------------------------
  // frame engine and registers
  // ----------------------------------------
  frame_e st_r, st_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [15:0] clock_r, clock_nxt;
  logic [15:0] dcblk_nxt;
  logic [15:0] rsvd_r, rsvd_nxt;
  logic [31:0] tx_r, tx_nxt;
  logic [31:0] rx_r, rx_nxt;
  logic [5:0] bit_r, bit_nxt;
  logic [2:0] word_r, word_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic sdo_nxt, oe_nxt;
  logic data_ready_n_nxt, sync_nxt;
  logic [3:0] pulse_r, pulse_nxt;
  logic [5:0] wbits;
  wlen_t wl;
  always_comb begin
    wl = mode_r[`MODE_WLEN_LSB +: 2];
    unique case (wl)
      `WLEN_16: wbits = 6'd16;
      `WLEN_24: wbits = 6'd24;
      default: wbits = 6'd32;
    endcase
  end
  // word k of the current frame, left aligned to 32 bits except in WLEN_32S, which sign-extends
  function automatic logic [31:0] frame_word(input logic [2:0] k, input wlen_t w,
      input logic [71:0] h, input logic [15:0] stat);
    logic [23:0] s;
    s = 24'h0;
    if (k == 3'h0) return {stat, 16'h0};
    if (k <= 3'h3) s = h[24*(k-3'h1) +: 24];
    else return 32'h0; // crc slot, not computed here
    unique case (w)
      `WLEN_16: return {s[23:8], 16'h0};
      `WLEN_24: return {s, 8'h0};
      `WLEN_32Z: return {s, 8'h0};
      default: return {{8{s[23]}}, s};
    endcase
  endfunction
  wire ch_off = (clock_r[`CLOCK_CH_LSB +: 3] == 3'h0);
  wire [2:0] last_word = CRC_EN ? 3'(NW - 1) : 3'(NW - 2);
  wire [15:0] status = {2'b00, qcount != 2'h0, 5'h0, wl, 6'h0};
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    clock_nxt = clock_r;
    dcblk_nxt = dcblk_cfg_r;
    rsvd_nxt = rsvd_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    bit_nxt = bit_r;
    word_nxt = word_r;
    cmd_nxt = cmd_r;
    sdo_nxt = sdo_o;
    oe_nxt = !cs_s;
    pop = 1'b0;
    sync_nxt = sync_seen_r || !sync_s;
    pulse_nxt = (pulse_r != 4'h0) ? pulse_r - 4'h1 : 4'h0;
    if (conv_valid && !(qcount == 2'h2)) pulse_nxt = `DATA_READY_N_PULSE_CYCLES;
    data_ready_n_nxt = mode_r[`MODE_DATA_READY_N_PULSE_BIT] ? (pulse_nxt == 4'h0) : (qcount == 2'h0);
    unique case (st_r)
      ST_IDLE: begin
        if (!cs_s) begin
          st_nxt = ST_SHIFT;
          word_nxt = 3'h0;
          bit_nxt = 6'h0;
          tx_nxt = frame_word(3'h0, wl, head, status);
          sdo_nxt = tx_nxt[31];
        end
      end
      ST_SHIFT: begin
        if (cs_s) begin
          // short frame: end in ST_DONE only if channels are off after two words
          st_nxt = ST_IDLE;
          if (ch_off && word_r >= 3'h2) st_nxt = ST_DONE;
        end else if (sclk_fall) begin
          rx_nxt = {rx_r[30:0], sdi_s};
          bit_nxt = bit_r + 6'h1;
          if (bit_r + 6'h1 == wbits) begin
            bit_nxt = 6'h0;
            if (word_r == 3'h0) cmd_nxt = rx_nxt[15:0];
            // opcode in the top three bits, so all 64 addresses are reachable
            if (word_r == 3'h1 && cmd_r[15:13] == `CMD_WREG) begin
              unique case (cmd_r[12:7])
                `REG_MODE: mode_nxt = rx_nxt[15:0];
                `REG_CLOCK: clock_nxt = rx_nxt[15:0];
                `REG_DCBLK: dcblk_nxt = rx_nxt[15:0];
                `REG_RSVD: rsvd_nxt = rx_nxt[15:0];
                default: ;
              endcase
            end
            if (word_r == last_word) begin
              st_nxt = ST_DONE;
              pop = 1'b1;
            end
            word_nxt = word_r + 3'h1;
            tx_nxt = frame_word(word_nxt, wl, head, status);
          end else begin
            tx_nxt = {tx_r[30:0], 1'b0};
          end
        end else if (sclk_rise) begin
          sdo_nxt = tx_r[31];
        end
      end
      ST_DONE: begin
        if (cs_s) st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      mode_r <= `MODE_RESET;
      clock_r <= `CLOCK_RESET;
      dcblk_cfg_r <= `DCBLK_RESET;
      rsvd_r <= `RSVD_RESET;
      tx_r <= 32'h0;
      rx_r <= 32'h0;
      bit_r <= 6'h0;
      word_r <= 3'h0;
      cmd_r <= 16'h0;
      sdo_o <= 1'b0;
      sdo_oe <= 1'b0;
      data_ready_n <= 1'b1;
      pulse_r <= 4'h0;
      sync_seen_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      clock_r <= clock_nxt;
      dcblk_cfg_r <= dcblk_nxt;
      rsvd_r <= rsvd_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      bit_r <= bit_nxt;
      word_r <= word_nxt;
      cmd_r <= cmd_nxt;
      sdo_o <= sdo_nxt;
      sdo_oe <= oe_nxt;
      data_ready_n <= data_ready_n_nxt;
      pulse_r <= pulse_nxt;
      sync_seen_r <= sync_nxt;
    end
  end
endmodule : adc_frame_serial_host_port
`default_nettype wire

// ### verification/frame_port_chk.sv
// Purpose: port checks of the serial host port
// Assumes: level data-ready mode
// Notes: bound into the port
`timescale 1ns/10ps
`default_nettype none
module frame_port_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cs_n,
  input wire logic sync_reset_n,
  input wire logic conv_valid,
  input wire logic sdo_oe,
  input wire logic data_ready_n,
  input wire logic [15:0] dcblk_cfg_r,
  input wire logic sync_seen_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  oe_off_a: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("output driven while deselected");
  oe_on_a: assert property ($fell(cs_n) ##1 !cs_n [*4] |-> sdo_oe)
    else $error("output not driven in frame");
  rst_out_a: assert property ($rose(rst_b) |-> !sdo_oe && data_ready_n
    && !sync_seen_r && dcblk_cfg_r == 16'h0000)
    else $error("bad values after reset");
  sync_keep_a: assert property (sync_seen_r |=> sync_seen_r)
    else $error("sync flag lost");
  sync_set_a: assert property (!sync_reset_n [*4] |-> ##[0:2] sync_seen_r)
    else $error("sync pulse missed");
  data_ready_n_new_a: assert property (conv_valid |-> ##[1:3] !data_ready_n)
    else $error("no data ready after result");
  data_ready_n_cause_a: assert property ($fell(data_ready_n) |->
    $past(conv_valid) || $past(conv_valid, 2) || $past(conv_valid, 3))
    else $error("data ready without result");
  cfg_hold_a: assert property (cs_n [*8] |-> $stable(dcblk_cfg_r))
    else $error("config changed outside frame");
endmodule : frame_port_chk
bind adc_frame_serial_host_port frame_port_chk u_chk (.mclk(mclk), .rst_b(rst_b),
  .cs_n(cs_n), .sync_reset_n(sync_reset_n), .conv_valid(conv_valid), .sdo_oe(sdo_oe),
  .data_ready_n(data_ready_n), .dcblk_cfg_r(dcblk_cfg_r), .sync_seen_r(sync_seen_r));
`default_nettype wire

// ### verification/spi_host_model.sv
// Purpose: serial controller on the host side
// Assumes: sclk half period of 4 mclk
// Notes: released output reads as inverse of last bit
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input wire logic mclk,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  logic last_r;
  logic line;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    last_r = 1'b0;
  end
  always_comb line = sdo_oe ? sdo_o : ~last_r;
  always @(posedge mclk) if (sdo_oe) last_r <= sdo_o;
  // only this select is ever driven, held through a frame
  // select toggles per frame, never tied low, so no crc is needed
  task automatic sel(input logic b);
    @(posedge mclk);
    cs_n <= b;
    repeat (8) @(posedge mclk);
  endtask : sel
  task automatic word(input int n, input logic [31:0] d, output logic [31:0] q);
    q = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge mclk);
      sclk <= 1'b1;
      sdi <= d[i];
      repeat (3) @(posedge mclk);
      // target shifts on the rising edge, so read just before the fall
      @(negedge mclk);
      q[i] = line;
      @(posedge mclk);
      sclk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask : word
endmodule : spi_host_model
`default_nettype wire

// ### verification/adc_frame_serial_host_port_tb.sv
// Purpose: self-checking bench of the serial host port
// Assumes: level data-ready mode, no crc word
// Notes: host side kept in spi_host_model
`timescale 1ns/10ps
`default_nettype none
module adc_frame_serial_host_port_tb;
  import adc_port_pkg::*;
  logic mclk, rst_b, sclk, cs_n, sdi, sdo_o, sdo_oe, data_ready_n, sync_reset_n;
  logic conv_valid, sync_seen_r;
  sample_t ch0, ch1, ch2;
  logic [15:0] dcblk_cfg_r;
  logic [31:0] got [4];
  int failures, checks_done;
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  adc_frame_serial_host_port u_dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .data_ready_n(data_ready_n),
    .sync_reset_n(sync_reset_n), .conv_valid(conv_valid), .conv_ch0(ch0), .conv_ch1(ch1),
    .conv_ch2(ch2), .dcblk_cfg_r(dcblk_cfg_r), .sync_seen_r(sync_seen_r));
  spi_host_model u_host (.mclk(mclk), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi));
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic frame(input int n, input int k, input logic [31:0] w0, input logic [31:0] w1);
    u_host.sel(1'b0);
    for (int i = 0; i < k; i++) begin
      u_host.word(n, i == 0 ? w0 : (i == 1 ? w1 : 32'h0), got[i]);
    end
    u_host.sel(1'b1);
  endtask : frame
  task automatic convert(input sample_t a, input sample_t b, input sample_t c);
    @(posedge mclk);
    ch0 <= a;
    ch1 <= b;
    ch2 <= c;
    conv_valid <= 1'b1;
    @(posedge mclk);
    conv_valid <= 1'b0;
    for (int i = 0; i < 20 && data_ready_n !== 1'b0; i++) @(negedge mclk);
    if (data_ready_n !== 1'b0) begin
      failures++;
      close_out();
    end
  endtask : convert
  task automatic t_read24();
    chk("data_ready_n", 32'(data_ready_n), 32'h1);
    chk("dcblk", 32'(dcblk_cfg_r), 32'h0);
    convert(24'h812345, 24'h000001, 24'h7fffff);
    frame(24, 4, 32'h0, 32'h0);
    chk("ch0", got[1], 32'h00812345);
    chk("ch1", got[2], 32'h00000001);
    chk("ch2", got[3], 32'h007fffff);
    repeat (4) @(negedge mclk);
    chk("data_ready_n", 32'(data_ready_n), 32'h1);
  endtask : t_read24
  task automatic t_cfg();
    frame(24, 4, 32'h6180, 32'h000e);
    frame(24, 2, 32'h6780, 32'h0009);
    frame(24, 2, 32'h7f80, 32'h0000);
    frame(24, 2, 32'h6100, 32'h0710);
    frame(32, 2, 32'h6180, 32'h0f0e);
    chk("dcblk", 32'(dcblk_cfg_r), 32'h9);
  endtask : t_cfg
  task automatic t_read32();
    convert(24'h800010, 24'h123456, 24'hfffffe);
    frame(32, 4, 32'h0, 32'h0);
    chk("ch0", got[1], 32'hff800010);
    chk("ch1", got[2], 32'h00123456);
    chk("ch2", got[3], 32'hfffffffe);
    convert(24'h000011, 24'h0, 24'h0);
    convert(24'h000022, 24'h0, 24'h0);
    convert(24'h000033, 24'h0, 24'h0);
    frame(32, 4, 32'h0, 32'h0);
    chk("older", got[1], 32'h22);
    frame(32, 4, 32'h0, 32'h0);
    chk("newer", got[1], 32'h33);
  endtask : t_read32
  task automatic t_sync();
    chk("sync", 32'(sync_seen_r), 32'h0);
    @(posedge mclk);
    sync_reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    sync_reset_n <= 1'b1;
    @(negedge mclk);
    chk("sync", 32'(sync_seen_r), 32'h1);
  endtask : t_sync
  initial begin
    #2000000;
    failures++;
    close_out();
  end
  initial begin
    rst_b = 1'b0;
    sync_reset_n = 1'b1;
    conv_valid = 1'b0;
    ch0 = '0;
    ch1 = '0;
    ch2 = '0;
    failures = 0;
    checks_done = 0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    t_read24();
    t_cfg();
    t_read32();
    t_sync();
    close_out();
  end
endmodule : adc_frame_serial_host_port_tb
`default_nettype wire
